/* logic/device_status_and_checksum_regs.sv */
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - each record status bit is high exactly while its channel is powered up
// - each playback status bit is high exactly while its channel is powered up
// - mode field bits 7-5: 4 sleep, 6 active idle, 7 active running
// - bit 4 reads one while the clock multiplier is enabled
// - bit 3 reads one while the mic bias supply is enabled and the device is not asleep
// - checksum register reads the checksum; a write replaces it with the data
// - writes to any other register, any page, update the checksum
// - playback channel powers up only if enabled and global control is set
module device_status_and_checksum_regs
  import status_regs_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int NUM_REC = 4,
  parameter int NUM_PLAY = 4,
  parameter int MODE_W = 3
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire ctrl_req_s req,
  input wire power_ctl_s pwr,
  output logic [7:0] rdata,
  output logic rvalid
);

  // ==========================================================
  // elaboration checks

  // all channels share one status byte, so the counts cannot
  // move without a new register layout
  if (DATA_W != 8) begin : g_bad_data_w
    $error("data width must be 8");
  end

  if (NUM_REC != 4) begin : g_bad_num_rec
    $error("record channel count must be 4");
  end

  if (NUM_PLAY != 4) begin : g_bad_num_play
    $error("playback channel count must be 4");
  end

  if (NUM_REC + NUM_PLAY != DATA_W) begin : g_bad_split
    $error("channel bits must fill the status byte");
  end

  if (MODE_W != MODE_MSB - MODE_LSB + 1) begin : g_bad_mode_w
    $error("mode field width must match its position");
  end

  // ==========================================================
  // helpers

  // a channel is up only when its own enable and the group
  // power control agree, and never while the device sleeps
  function automatic logic [3:0] chan_on(
    input logic [3:0] enable,
    input logic group_on,
    input logic asleep
  );
    chan_on = enable & {4{group_on & ~asleep}};
  endfunction

  // sleep outranks activity; reserved codes are never produced
  function automatic logic [2:0] mode_code(
    input logic asleep,
    input logic any_on
  );
    if (asleep) begin
      mode_code = MODE_SLEEP;
    end else if (any_on) begin
      mode_code = MODE_ACTIVE_RUN;
    end else begin
      mode_code = MODE_ACTIVE_IDLE;
    end
  endfunction

  function automatic logic addr_hit(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    addr_hit = (addr == ofs);
  endfunction

  // ==========================================================
  // request decode
  logic wr_take;
  logic rd_take;

  always_comb begin
    wr_take = req.wr;
    // a read colliding with a write is dropped, the write wins
    rd_take = req.rd & ~req.wr;
  end

  // ==========================================================
  // status registers
  logic [7:0] chan_status_q;
  logic [7:0] chan_status_d;
  logic [7:0] mode_status_q;
  logic [7:0] mode_status_d;
  logic [3:0] rec_on;
  logic [3:0] play_on;
  logic any_on;
  logic [2:0] mode;

  always_comb begin
    rec_on = chan_on(pwr.record_enable, pwr.record_power_control, pwr.sleep);
    play_on = chan_on(pwr.playback_enable, pwr.playback_power_control, pwr.sleep);
    any_on = |{rec_on, play_on};
    mode = mode_code(pwr.sleep, any_on);
    // status comes only from power state, bus writes never reach here
    chan_status_d = {rec_on, play_on};
    mode_status_d = 8'h00;
    mode_status_d[MODE_MSB:MODE_LSB] = mode;
    mode_status_d[CLK_MULT_BIT] = pwr.clock_multiplier_on;
    mode_status_d[MIC_BIAS_BIT] = pwr.mic_bias_supply & ~pwr.sleep;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chan_status_q <= CHAN_POWER_STATUS_RST;
      mode_status_q <= DEVICE_MODE_STATUS_RST;
    end else if (clk_en) begin
      chan_status_q <= chan_status_d;
      mode_status_q <= mode_status_d;
    end
  end

  // ==========================================================
  // checksum
  logic [7:0] cksum_q;
  logic [7:0] cksum_d;
  logic [7:0] cksum_next;

  transaction_checksum_calc u_calc (
    .sum_in(cksum_q),
    .addr(req.addr),
    .data(req.wdata),
    .sum_out(cksum_next)
  );

  always_comb begin
    cksum_d = cksum_q;
    if (wr_take) begin
      if (addr_hit(req.addr, WRITE_CHECKSUM_OFS)) begin
        cksum_d = req.wdata;
      end else begin
        // page number ignored on purpose: every page counts,
        // and writes to the status registers count as well
        cksum_d = cksum_next;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cksum_q <= WRITE_CHECKSUM_RST;
    end else if (clk_en) begin
      cksum_q <= cksum_d;
    end
  end

  // ==========================================================
  // read port, one cycle latency
  logic [7:0] rdata_d;
  logic rvalid_d;

  always_comb begin
    rvalid_d = rd_take;
    if (!rd_take) begin
      // data bus held at zero between answers
      rdata_d = 8'h00;
    end else if (addr_hit(req.addr, CHAN_POWER_STATUS_OFS)) begin
      rdata_d = chan_status_q;
    end else if (addr_hit(req.addr, DEVICE_MODE_STATUS_OFS)) begin
      rdata_d = mode_status_q;
    end else if (addr_hit(req.addr, WRITE_CHECKSUM_OFS)) begin
      rdata_d = cksum_q;
    end else begin
      // unmapped offsets read as zero
      rdata_d = 8'h00;
    end
  end

  // clk_en low stretches the answer rather than dropping it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else if (clk_en) begin
      rdata <= rdata_d;
      rvalid <= rvalid_d;
    end
  end

endmodule // device_status_and_checksum_regs

`default_nettype wire

/* logic/status_regs_pkg.sv */
`default_nettype none

package status_regs_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] CHAN_POWER_STATUS_OFS = 8'h79;
  localparam logic [7:0] DEVICE_MODE_STATUS_OFS = 8'h7a;
  localparam logic [7:0] WRITE_CHECKSUM_OFS = 8'h7e;

  localparam logic [7:0] CHAN_POWER_STATUS_RST = 8'h00;
  localparam logic [7:0] DEVICE_MODE_STATUS_RST = 8'h80;
  localparam logic [7:0] WRITE_CHECKSUM_RST = 8'h00;

  // ==========================================================
  // field positions
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 5;
  localparam int CLK_MULT_BIT = 4;
  localparam int MIC_BIAS_BIT = 3;

  // ==========================================================
  // mode codes
  localparam logic [2:0] MODE_SLEEP = 3'h4;
  localparam logic [2:0] MODE_ACTIVE_IDLE = 3'h6;
  localparam logic [2:0] MODE_ACTIVE_RUN = 3'h7;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [6:0] page;
  } ctrl_req_s;

  typedef struct packed {
    logic [3:0] record_enable;
    logic [3:0] playback_enable;
    logic record_power_control;
    logic playback_power_control;
    logic mic_bias_supply;
    logic clock_multiplier_on;
    logic sleep;
  } power_ctl_s;

endpackage

`default_nettype wire

/* logic/transaction_checksum_calc.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// running checksum step: rotate-left then xor the written data,
// address folded in so that same data at two addresses differ
module transaction_checksum_calc (
  input wire logic [7:0] sum_in,
  input wire logic [7:0] addr,
  input wire logic [7:0] data,
  output logic [7:0] sum_out
);
  always_comb begin
    sum_out = {sum_in[6:0], sum_in[7]} ^ data ^ addr;
  end
endmodule // transaction_checksum_calc

`default_nettype wire

/* verification/host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_model
  import status_regs_pkg::*;
(
  input wire logic clk,
  output var ctrl_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial req = '0;
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [8:0] q);
    @(posedge clk);
    #2 req = '{w, ~w, a, d, d[6:0]};
    @(posedge clk);
    #2 q = {rvalid, rdata};
    // idle lines flipped so a stale request is never read as live
    req = '{1'b0, 1'b0, ~a, ~d, 7'h00};
  endtask
endmodule // host_model
`default_nettype wire

/* verification/status_regs_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module status_regs_assertions
  import status_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire ctrl_req_s req,
  input wire power_ctl_s pwr,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  wire g = clk_en & req.rd & ~req.wr;
  wire s0 = g & (req.addr == 8'h79);
  wire s1 = g & (req.addr == 8'h7a);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_ans; g |=> rvalid; endproperty
  a_ans: assert property (p_ans) else $error("read unanswered");
  property p_idle; clk_en && !g |=> !rvalid && rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_ck; clk_en && req.wr && req.addr == 8'h7e ##1 !req.wr && clk_en
    ##1 g && req.addr == 8'h7e |=> rdata == $past(req.wdata, 3); endproperty
  a_ck: assert property (p_ck) else $error("preset lost");
  property p_code; s1 |=> rdata[7:5] inside {3'h4, 3'h6, 3'h7}; endproperty
  a_code: assert property (p_code) else $error("bad mode");
  property p_rsv; s1 |=> rdata[2:0] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("low bits set");
  // sleep forces every channel off, so status must read all zero
  property p_off; s0 && $past(pwr.sleep) && $past(clk_en) |=> rdata == 8'h00; endproperty
  a_off: assert property (p_off) else $error("channel on");
  property p_slp; s1 && $past(pwr.sleep) && $past(clk_en)
    |=> {rdata[7:5], rdata[3]} == 4'h8; endproperty
  a_slp: assert property (p_slp) else $error("sleep status");
  property p_pll; s1 && $past(clk_en) && $past(rstn) && $stable(pwr)
    |=> rdata[4] == $past(pwr.clock_multiplier_on); endproperty
  a_pll: assert property (p_pll) else $error("multiplier status");
  property p_frz; !clk_en |=> $stable(rdata) && $stable(rvalid); endproperty
  a_frz: assert property (p_frz) else $error("outputs moved while frozen");
endmodule // status_regs_assertions
bind device_status_and_checksum_regs status_regs_assertions u_chk (.clk(clk), .rstn(rstn),
  .clk_en(clk_en), .req(req), .pwr(pwr), .rdata(rdata), .rvalid(rvalid));
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench import status_regs_pkg::*;;
  logic clk = 0, rstn = 0, clk_en = 1;
  ctrl_req_s req;
  power_ctl_s pwr = 13'h0001;
  logic [7:0] rdata;
  logic rvalid;
  logic [8:0] q;
  int bad_count = 0, num_checks = 0;
  // {power, write, address, data or expected}
  logic [29:0] ts [12] = '{30'h00027900, 30'h00027a80, 30'h00027e00, 30'h00021000,
    30'h296879a0, 30'h29687ae8, 30'h29547905, 30'h29547af0,
    30'h3fcc7900, 30'h3fcc7ad8, 30'h3ffe7900, 30'h3ffe7a90};
  logic [29:0] tc [8] = '{30'h3fff7e5a, 30'h3ffe7e5a, 30'h3fff793c, 30'h3ffe7900,
    30'h3ffe7ef1, 30'h3fff7ae0, 30'h3ffe7a90, 30'h3ffe7e79};
  device_status_and_checksum_regs u_device_status_and_checksum_regs (.clk(clk), .rstn(rstn),
    .clk_en(clk_en), .req(req), .pwr(pwr), .rdata(rdata), .rvalid(rvalid));
  host_model u_host_model (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  initial forever #12.5 clk = ~clk;
  task chk(input logic [8:0] seen, input logic [8:0] want);
    num_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task run(input logic [29:0] t);
    pwr = t[29:17];
    u_host_model.op(t[16], t[15:8], t[7:0], q);
    chk(q, t[16] ? 9'h000 : {1'b1, t[7:0]});
  endtask
  task t_status;
    foreach (ts[i]) run(ts[i]);
  endtask
  task t_cksum;
    foreach (tc[i]) run(tc[i]);
  endtask
  // write while frozen must be lost and the last answer must stand
  task t_freeze;
    clk_en = 0;
    u_host_model.op(1'b1, 8'h7e, 8'h33, q);
    chk(q, 9'h179);
    clk_en = 1;
    run(30'h3ffe7e79);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #2 rstn = 1;
    t_status;
    t_cksum;
    t_freeze;
    summarize;
  end
  initial begin
    #20000 bad_count++;
    summarize;
  end
endmodule // testbench
`default_nettype wire
